// *** rgbr_regs.svh ***
`ifndef RGBR_REGS_SVH
`define RGBR_REGS_SVH
// Link clock that the bench drives, in ns
`define RGBR_LINK_CLK_NS      160
`define RGBR_SYS_CLK_NS       20
// Transmit clock half period in system cycles for the fastest link
`define RGBR_TXCLK_HALF       (`RGBR_LINK_CLK_NS / `RGBR_SYS_CLK_NS / 2)
`define RGBR_TXCLK_HALF_W     8
`define RGBR_DELAY_W          8
`define RGBR_FIFO_DEPTH       16
`define RGBR_STAT_EN_BIT      0
`define RGBR_STAT_SKEW_BIT    1
// Link pin positions on the shared pad group
`define RGBR_PIN_TXD          0
`define RGBR_PIN_TXCLK        4
`define RGBR_PIN_TXCTL        5
`define RGBR_PIN_RXCLK        6
`define RGBR_PIN_RXCTL        7
`define RGBR_PIN_RXD          8
`define RGBR_PIN_OE_MASK      12'h03F
`endif

// *** rgbr_pkg.sv ***
package rgbr_pkg;
	typedef struct packed {
		logic [3:0] data;
		logic       ctl;
		logic       clk;
	} rgbr_ddr_s;

	typedef struct packed {
		logic [7:0] data;
		logic       valid;
		logic       error;
	} rgbr_sdr_s;

	typedef struct packed {
		logic [11:0] pin_out;
		logic [11:0] pin_oe;
	} rgbr_gpio_s;
endpackage : rgbr_pkg

// *** rgbr_fifo.sv ***
`timescale 1ns/1ps
`default_nettype none
module rgbr_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 16
) (
	input  wire logic             i_clk,
	input  wire logic             i_rst,
	input  wire logic [WIDTH-1:0] i_data,
	input  wire logic             i_valid,
	output logic                  o_ready,
	output logic      [WIDTH-1:0] o_data,
	output logic                  o_valid,
	input  wire logic             i_ready
);
	localparam int AW = $clog2(DEPTH);

	typedef struct packed {
		logic [DEPTH-1:0][WIDTH-1:0] mem;
		logic [AW-1:0]               wr;
		logic [AW-1:0]               rd;
		logic [AW:0]                 cnt;
	} rgbr_fifo_s;

	rgbr_fifo_s s_q;
	rgbr_fifo_s s_d;
	logic       push;
	logic       pop;

	assign o_ready = (s_q.cnt != (AW+1)'(DEPTH));
	assign o_valid = (s_q.cnt != '0);
	assign o_data  = s_q.mem[s_q.rd];
	assign push    = i_valid && o_ready;
	assign pop     = o_valid && i_ready;

	always_comb
	begin
		s_d = s_q;
		if (push)
		begin
			s_d.mem[s_q.wr] = i_data;
			s_d.wr = (s_q.wr == AW'(DEPTH - 1)) ? '0 : s_q.wr + 1'b1;
		end
		if (pop)
			s_d.rd = (s_q.rd == AW'(DEPTH - 1)) ? '0 : s_q.rd + 1'b1;
		s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			s_q.wr  <= '0;
			s_q.rd  <= '0;
			s_q.cnt <= '0;
			s_q.mem <= '0;
		end
		else
			s_q <= s_d;
	end
endmodule : rgbr_fifo
`default_nettype wire

// *** rgbr_bridge.sv ***
`timescale 1ns/1ps
`default_nettype none
`include "rgbr_regs.svh"
module rgbr_bridge (
	input  wire logic                 i_clk,
	input  wire logic                 i_rst,
	input  wire logic [1:0]           i_status,
	input  wire logic [`RGBR_DELAY_W-1:0] i_clk_delay,
	input  wire rgbr_pkg::rgbr_gpio_s i_gpio,
	input  wire logic [11:0]          i_pin_in,
	output rgbr_pkg::rgbr_gpio_s      o_pins,
	output rgbr_pkg::rgbr_sdr_s       o_rx,
	output logic                      o_rx_valid,
	input  wire logic                 i_rx_ready,
	input  wire rgbr_pkg::rgbr_sdr_s  i_tx,
	input  wire logic                 i_tx_valid,
	output logic                      o_tx_ready,
	output logic                      o_port_busy,
	output logic                      o_rx_overflow
);
	import rgbr_pkg::*;

	localparam int RGBR_WORD_W = $bits(rgbr_sdr_s);

	typedef enum logic [1:0] {
		RGBR_TX_LOW  = 2'b01,
		RGBR_TX_HIGH = 2'b10
	} rgbr_tx_e;

	typedef struct packed {
		logic [1:0]                   rxclk_sync;
		logic [1:0]                   rxctl_sync;
		logic [1:0][3:0]              rxd_sync;
		logic                         rxclk_prev;
		logic [3:0]                   lo_nib;
		logic                         lo_ctl;
		rgbr_sdr_s                    rx_word;
		logic                         rx_push;
		logic                         overflow;
		logic [`RGBR_TXCLK_HALF_W-1:0] half_cnt;
		logic                         tx_phase;
		rgbr_tx_e                     tx_state;
		rgbr_sdr_s                    tx_word;
		logic [3:0]                   txd;
		logic                         txctl;
		logic [`RGBR_DELAY_W-1:0]     dly_cnt;
		logic                         txclk;
	} rgbr_state_s;

	rgbr_state_s s_q;
	rgbr_state_s s_d;
	logic        enable;
	logic        skew;
	logic        rx_fifo_ready;
	logic [RGBR_WORD_W-1:0] rx_fifo_data;
	logic        half_done;
	logic        rx_rise;
	logic        rx_fall;
	logic        rx_pin_clk;
	logic        rx_pin_ctl;
	logic [3:0]  rx_pin_data;
	logic        tx_slot;
	logic        tx_take;
	logic        clk_edge_now;
	logic        clk_edge_late;

	assign enable = i_status[`RGBR_STAT_EN_BIT];
	assign skew   = i_status[`RGBR_STAT_SKEW_BIT];
	assign half_done = (s_q.half_cnt ==
		`RGBR_TXCLK_HALF_W'(`RGBR_TXCLK_HALF - 1));
	assign rx_rise = s_q.rxclk_sync[1] && !s_q.rxclk_prev;
	assign rx_fall = !s_q.rxclk_sync[1] && s_q.rxclk_prev;
	assign o_port_busy = enable;
	// A byte is only taken at the end of a low-nibble half, as the high nibble goes out
	assign tx_slot     = half_done && s_q.tx_phase;
	assign o_tx_ready  = enable && (s_q.tx_state == RGBR_TX_HIGH) &&
		tx_slot;
	assign o_rx_overflow = s_q.overflow;

	assign tx_take       = o_tx_ready && i_tx_valid;
	assign rx_pin_clk    = i_pin_in[`RGBR_PIN_RXCLK];
	assign rx_pin_ctl    = i_pin_in[`RGBR_PIN_RXCTL];
	assign rx_pin_data   = i_pin_in[`RGBR_PIN_RXD +: 4];
	// Without skew the clock moves with the data, with skew it trails it
	assign clk_edge_now  = half_done && !skew;
	assign clk_edge_late = skew && (s_q.dly_cnt == `RGBR_DELAY_W'(1));

	// Pin map: 0-3 TX data, 4 TX clock, 5 TX control, 6 RX clock,
	// 7 RX control, 8-11 RX data
	always_comb
	begin
		o_pins = i_gpio;
		if (enable)
		begin
			// Receive pins are inputs here, so their output bits stay low
			o_pins.pin_out = '0;
			o_pins.pin_out[`RGBR_PIN_TXD +: 4] = s_q.txd;
			o_pins.pin_out[`RGBR_PIN_TXCLK]    = s_q.txclk;
			o_pins.pin_out[`RGBR_PIN_TXCTL]    = s_q.txctl;
			o_pins.pin_oe  = `RGBR_PIN_OE_MASK;
		end
	end

	always_comb
	begin
		s_d = s_q;
		s_d.rx_push = 1'b0;
		// Two-stage synchronisers on every inbound link pin
		s_d.rxclk_sync = {s_q.rxclk_sync[0], rx_pin_clk};
		s_d.rxctl_sync = {s_q.rxctl_sync[0], rx_pin_ctl};
		s_d.rxd_sync   = {s_q.rxd_sync[0], rx_pin_data};
		s_d.rxclk_prev = s_q.rxclk_sync[1];
		if (enable && rx_rise)
		begin
			s_d.lo_nib = s_q.rxd_sync[1];
			s_d.lo_ctl = s_q.rxctl_sync[1];
		end
		if (enable && rx_fall)
		begin
			s_d.rx_word.data  = {s_q.rxd_sync[1], s_q.lo_nib};
			s_d.rx_word.valid = s_q.lo_ctl;
			s_d.rx_word.error = s_q.lo_ctl ^ s_q.rxctl_sync[1];
			// Idle bytes are dropped so the FIFO only carries frame data and error bytes
			s_d.rx_push = s_q.lo_ctl || s_d.rx_word.error;
		end
		// Lost bytes cannot be recovered; flag until the mode is dropped
		if (enable && s_q.rx_push && !rx_fifo_ready)
			s_d.overflow = 1'b1;
		else if (!enable)
			s_d.overflow = 1'b0;

		s_d.half_cnt = half_done ? '0 : s_q.half_cnt + 1'b1;
		if (half_done)
			s_d.tx_phase = !s_q.tx_phase;
		if (!enable)
		begin
			s_d.tx_state = RGBR_TX_LOW;
			s_d.txd      = 4'h0;
			s_d.txctl    = 1'b0;
		end
		else if (half_done)
		begin
			unique case (s_q.tx_state)
				RGBR_TX_LOW:
				begin
					if (!s_q.tx_phase)
					begin
						s_d.txd      = s_q.tx_word.data[3:0];
						s_d.txctl    = s_q.tx_word.valid;
						s_d.tx_state = RGBR_TX_HIGH;
					end
				end
				RGBR_TX_HIGH:
				begin
					s_d.txd   = s_q.tx_word.data[7:4];
					s_d.txctl = s_q.tx_word.valid ^ s_q.tx_word.error;
					s_d.tx_state = RGBR_TX_LOW;
					// No byte offered: an idle byte goes out next
					s_d.tx_word  = tx_take ? i_tx : '0;
				end
				default:
					s_d.tx_state = RGBR_TX_LOW;
			endcase
		end
		// Delayed clock edge trails the data by a programmable count
		if (half_done)
			s_d.dly_cnt = skew ? i_clk_delay : '0;
		else if (s_q.dly_cnt != '0)
			s_d.dly_cnt = s_q.dly_cnt - 1'b1;
		// A delay of zero or of more than a half period never counts down
		// to one, so the delayed clock then stands still
		if (clk_edge_now)
			s_d.txclk = enable && !s_q.tx_phase;
		else if (clk_edge_late)
			// The phase has already turned by the time the delay runs out
			s_d.txclk = enable && s_q.tx_phase;
	end

	always_ff @(posedge i_clk)
	begin
		if (i_rst)
		begin
			s_q          <= '0;
			s_q.tx_state <= RGBR_TX_LOW;
		end
		else
			s_q <= s_d;
	end

	assign rx_fifo_data = s_q.rx_word;

	// Dropping the mode flushes stale bytes so a new session starts clean
	rgbr_fifo #(
		.WIDTH(RGBR_WORD_W),
		.DEPTH(`RGBR_FIFO_DEPTH)
	) u_rx_fifo (
		.i_clk  (i_clk),
		.i_rst  (i_rst || !enable),
		.i_data (rx_fifo_data),
		.i_valid(s_q.rx_push),
		.o_ready(rx_fifo_ready),
		.o_data (o_rx),
		.o_valid(o_rx_valid),
		.i_ready(i_rx_ready)
	);
endmodule : rgbr_bridge
`default_nettype wire

// *** rgbr_bridge_sva.sv ***
`timescale 1ns/1ps
`default_nettype none
module rgbr_sva_chk (
	input wire logic                 i_clk,
	input wire logic                 i_rst,
	input wire logic [1:0]           i_status,
	input wire rgbr_pkg::rgbr_gpio_s i_gpio,
	input wire rgbr_pkg::rgbr_gpio_s o_pins,
	input wire rgbr_pkg::rgbr_sdr_s  o_rx,
	input wire logic                 o_rx_valid,
	input wire logic                 i_rx_ready,
	input wire logic                 o_tx_ready,
	input wire logic                 o_port_busy,
	input wire logic                 o_rx_overflow
);
	import rgbr_pkg::*;
	logic en;
	logic tc;
	assign en = i_status[0];
	assign tc = o_pins.pin_out[4];
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_rst);
	a_gpio_pass: assert property (!en && !$past(en) && $stable(i_gpio)
		|-> o_pins == i_gpio) else $error("gpio not passed");
	a_pins_owned: assert property (en && $past(en)
		|-> o_pins.pin_oe == 12'h03F) else $error("pin enables wrong");
	a_spare_low: assert property (en && $past(en)
		|-> o_pins.pin_out[11:6] == 6'h00) else $error("spare pins driven");
	a_busy_en: assert property (o_port_busy == en)
		else $error("busy not equal to enable");
	a_ready_gap: assert property (o_tx_ready |=> !o_tx_ready [*7])
		else $error("ready closer than 8");
	a_ready_off: assert property (o_tx_ready |-> en)
		else $error("ready while disabled");
	a_ovf_sticky: assert property (o_rx_overflow && en ##1 en
		|-> o_rx_overflow) else $error("overflow lost");
	a_off_clear: assert property (!en ##1 !en
		|-> !o_rx_overflow && !o_rx_valid) else $error("rx not cleared");
	a_head_held: assert property (o_rx_valid && !i_rx_ready ##1 en
		|-> o_rx_valid && $stable(o_rx)) else $error("rx head moved");
	a_txclk_half: assert property ($rose(tc) && i_status == 2'b01
		|-> (tc || i_status != 2'b01) [*4] ##1 (!tc || i_status != 2'b01))
		else $error("tx clock half wrong");
endmodule : rgbr_sva_chk
bind rgbr_bridge rgbr_sva_chk u_chk (.i_clk, .i_rst, .i_status, .i_gpio,
	.o_pins, .o_rx, .o_rx_valid, .i_rx_ready, .o_tx_ready, .o_port_busy,
	.o_rx_overflow);
`default_nettype wire

// *** rgbr_phy_model.sv ***
`timescale 1ns/1ps
`default_nettype none
module rgbr_phy_model (
	output logic [5:0] o_rx
);
	initial o_rx = 6'h00;
	// Clock stands low between frames, as a PHY held in reset would
	task automatic send(input logic [7:0] b, input logic v, input logic e);
		o_rx = {b[3:0], v, 1'b0};
		#40 o_rx[0] = 1'b1;
		#40 o_rx[5:1] = {b[7:4], v ^ e};
		#40 o_rx[0] = 1'b0;
		// High nibble stands through the low half, so back-to-back calls
		// keep the link period and the falling edge never meets new data
		#40;
	endtask : send
endmodule : rgbr_phy_model
`default_nettype wire

// *** rgbr_bridge_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module rgbr_bridge_tb_top;
	import rgbr_pkg::*;
	logic       clk = 0;
	logic       rst = 1;
	logic       rx_rdy = 0;
	logic       tx_v = 0;
	logic [1:0] st = 0;
	logic [7:0] dly = 0;
	rgbr_gpio_s gpio = '0;
	rgbr_gpio_s pins;
	rgbr_sdr_s  rx;
	rgbr_sdr_s  tx = '0;
	logic       rx_v, tx_rdy, busy, ovf;
	logic [5:0] phy_rx;
	int         mismatches = 0;
	int         cmp_count = 0;
	initial forever #10 clk = ~clk;
	rgbr_phy_model phy (.o_rx(phy_rx));
	rgbr_bridge dut (.i_clk(clk), .i_rst(rst), .i_status(st),
		.i_clk_delay(dly), .i_gpio(gpio), .i_pin_in({phy_rx, 6'h00}),
		.o_pins(pins), .o_rx(rx), .o_rx_valid(rx_v), .i_rx_ready(rx_rdy),
		.i_tx(tx), .i_tx_valid(tx_v), .o_tx_ready(tx_rdy),
		.o_port_busy(busy), .o_rx_overflow(ovf));
	task automatic chk(input logic [23:0] got, input logic [23:0] exp);
		cmp_count++;
		if (got !== exp)
		begin
			mismatches++;
			$display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
		end
	endtask : chk
	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask : cyc
	task automatic wait_clk(input logic v);
		int n = 0;
		while (pins.pin_out[4] !== v && n < 40)
		begin
			cyc(1);
			n++;
		end
		cyc(1);
	endtask : wait_clk
	task automatic pop(input logic [9:0] e);
		int n = 0;
		while (rx_v !== 1'b1 && n < 40)
		begin
			cyc(1);
			n++;
		end
		chk(24'(rx), 24'(e));
		rx_rdy = 1;
		cyc(1);
		rx_rdy = 0;
		cyc(1);
	endtask : pop
	task automatic t_gpio;
		gpio = '{pin_out: 12'hA5C, pin_oe: 12'h3C3};
		cyc(3);
		chk(24'(pins), 24'(gpio));
		chk(24'(busy), 24'h0);
	endtask : t_gpio
	task automatic t_rx;
		st = 2'b01;
		cyc(3);
		chk(24'(pins.pin_oe), 24'h03F);
		chk(24'(pins.pin_out[11:6]), 24'h0);
		chk(24'(busy), 24'h1);
		phy.send(8'h3C, 1'b1, 1'b0);
		phy.send(8'hA5, 1'b1, 1'b1);
		phy.send(8'h96, 1'b0, 1'b1);
		phy.send(8'h00, 1'b0, 1'b0);
		pop({8'h3C, 2'b10});
		pop({8'hA5, 2'b11});
		pop({8'h96, 2'b01});
		cyc(20);
		chk(24'(rx_v), 24'h0);
	endtask : t_rx
	task automatic t_ovf;
		for (int i = 0; i < 17; i++)
			phy.send(8'(i), 1'b1, 1'b0);
		cyc(10);
		chk(24'(ovf), 24'h1);
		for (int i = 0; i < 16; i++)
			pop({8'(i), 2'b10});
		chk(24'(rx_v), 24'h0);
		st = 2'b00;
		cyc(2);
		chk(24'(ovf), 24'h0);
	endtask : t_ovf
	task automatic t_tx(input logic [7:0] d);
		int n = 0;
		st = {d != 8'h00, 1'b1};
		dly = d;
		tx = '{data: 8'hB7, valid: 1'b1, error: 1'b1};
		tx_v = 1;
		while (tx_rdy !== 1'b1 && n < 20)
		begin
			cyc(1);
			n++;
		end
		cyc(1);
		tx_v = 0;
		n = 0;
		while (pins.pin_out[3:0] !== 4'h7 && n < 20)
		begin
			cyc(1);
			n++;
		end
		n = 0;
		while (pins.pin_out[4] !== 1'b1 && n < 8)
		begin
			cyc(1);
			n++;
		end
		chk(24'(n), 24'(d));
		chk(24'({pins.pin_out[5], pins.pin_out[3:0]}), 24'h17);
		wait_clk(1'b0);
		chk(24'({pins.pin_out[5], pins.pin_out[3:0]}), 24'h0B);
	endtask : t_tx
	task automatic summarize;
		$display("mismatches %0d comparisons %0d", mismatches, cmp_count);
		if (mismatches == 0 && cmp_count > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : summarize
	initial
	begin
		cyc(4);
		rst = 0;
		t_gpio();
		t_rx();
		t_ovf();
		t_tx(8'h00);
		t_tx(8'h02);
		summarize();
	end
	initial
	begin
		#300000;
		mismatches++;
		summarize();
	end
endmodule : rgbr_bridge_tb_top
`default_nettype wire
